// ---- verilog/spwm_pkg.sv ----
package spwm_pkg;
    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;     // module_control_reg
    localparam logic [7:0] ADDR_DUTYH = 8'h04;    // duty_high_buffer
    localparam logic [7:0] ADDR_DUTYACT = 8'h08;  // duty_active_reg
    localparam logic [7:0] ADDR_TSEL = 8'h0c;     // timer_select_reg
    localparam logic [7:0] ADDR_DIR = 8'h10;      // pin_direction_bit
    localparam logic [7:0] ADDR_PINSTAT = 8'h14;  // pin level and ownership
    localparam logic [7:0] ADDR_FLAGS = 8'h18;    // timer_match_flag per timer
    localparam logic [7:0] ADDR_TBASE = 8'h20;    // first timer block
    localparam logic [7:0] TSTRIDE = 8'h10;       // bytes per timer block
    localparam logic [7:0] OFS_TCTRL = 8'h00;     // timer_control_reg
    localparam logic [7:0] OFS_PERIOD = 8'h04;    // period_reg
    localparam logic [7:0] OFS_COUNT = 8'h08;     // timer_count
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_MODE_LSB = 0;     // mode field, 4 bits
    localparam int CTRL_DLOW_LSB = 4;     // duty_low_bits, 2 bits
    localparam int TCTRL_PS_LSB = 0;      // timer_prescale_sel, 2 bits
    localparam int TCTRL_RUN_BIT = 2;     // timer_run_bit
    localparam int TCTRL_POST_LSB = 3;    // postscale, 4 bits, stored only
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DUTYH = 8'h00;
    localparam logic [9:0] RST_DUTYACT = 10'h000;
    localparam logic [1:0] RST_TSEL = 2'h0;
    localparam logic RST_DIR = 1'b1;      // pin is input after reset
    localparam logic [6:0] RST_TCTRL = 7'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_COUNT = 8'h00;
    // ****************************************************************
    // prescaler: sub-counter end values, one timer tick per wrap
    // ****************************************************************
    localparam logic [5:0] SUB_END_PS1 = 6'h03;   // 4 clocks, 1:1
    localparam logic [5:0] SUB_END_PS4 = 6'h0f;   // 16 clocks, 1:4
    localparam logic [5:0] SUB_END_PS16 = 6'h3f;  // 64 clocks, 1:16
    localparam int NUM_TIMERS = 3;
    typedef enum logic [1:0] {PS_DIV1, PS_DIV4, PS_DIV16, PS_DIV16B} spwm_ps_t;
endpackage

// ---- verilog/spwm_generator.sv ----
// The APB interface to the registers and the register offsets were left to the implementer.
module spwm_generator #(
    parameter logic [3:0] PWM_MODE = 4'hc  // mode code for standard pwm
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sleep,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pwmOutPin,
    output logic pwmOutOe
);
    import spwm_pkg::*;

    // ****************************************************************
    // overview
    // ****************************************************************
    // apb slave with one wait state: setup, access, then pready for
    // one cycle; reads return the register in the low bits, upper
    // bits zero; unmapped offsets answer with pslverr and no effect
    // three timers, each with prescaler, count, period and flag;
    // a prescaler tick is a one-cycle enable, never a second clock
    // the 10-bit time base is the count above two prescaler bits,
    // so one time base step lasts one, four or sixteen clocks
    // the duty value is double buffered: software writes the
    // buffer, the active copy loads at a period start or, outside pwm, from the bus
    // the pin register falls at the edge where the time base
    // reaches the active duty, so high time is whole duty steps
    // hazard: a duty at or beyond the period length never meets
    // the time base, so the pin stays high through the period
    // limitation: timer select code three aliases the first timer
    // sleep freezes the timers and the pin, not the register bus

    // ****************************************************************
    // registers and state
    // ****************************************************************
    logic [7:0] moduleControlReg;           // mode and duty_low_bits
    logic [7:0] dutyHighBuffer;             // buffered duty, eight msbs
    logic [9:0] dutyActive;                 // duty_active_reg plus latch
    logic [1:0] timerSelect;                // timer_select
    logic pinDirectionBit;                  // high keeps driver off
    logic [6:0] timerControlReg [NUM_TIMERS];
    logic [7:0] periodReg [NUM_TIMERS];
    logic [7:0] timerCount [NUM_TIMERS];
    logic [5:0] subCount [NUM_TIMERS];      // prescaler and quarter count
    logic timerMatchFlag [NUM_TIMERS];
    logic periodStart [NUM_TIMERS];         // wrap event, comb
    logic [9:0] timeBase [NUM_TIMERS];      // 10-bit time base, comb
    logic timeStep [NUM_TIMERS]; // time base advances at this edge, comb
    logic pwmMode;                          // mode field is pwm
    logic access;                           // write/read takes effect
    logic wrEn;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic selStart;                         // selected timer period start
    logic [9:0] selBase;                    // selected time base
    logic selStep; // selected time base advances at this edge
    logic running;                          // pwm not frozen

    // mode decode and bus strobes
    assign pwmMode = (moduleControlReg[CTRL_MODE_LSB +: 4] == PWM_MODE);
    assign access = psel && penable && pready;
    assign wrEn = access && pwrite;
    assign running = pwmMode && !sleep;

    // ****************************************************************
    // apb handshake: one wait state, answer from flops
    // ****************************************************************
    // pready rises in the second access cycle, then drops
    always_ff @(posedge clock) begin
        if (rst) begin
            // no answer pending after reset
            pready <= 1'b0;
        end else begin
            // high in the cycle after penable rises, low again after
            pready <= psel && penable && !pready;
        end
    end

    // read data and error captured together with pready
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            // latch the answer so it stands beside pready
            // writes answer with zero data
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            // error stands only beside pready
            pslverr <= 1'b0;
        end
    end

    // read mux and decode of unmapped addresses
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            ADDR_CTRL: begin
                next_prdata[7:0] = moduleControlReg;
            end
            ADDR_DUTYH: begin
                next_prdata[7:0] = dutyHighBuffer;
            end
            ADDR_DUTYACT: begin
                next_prdata[9:0] = dutyActive;
            end
            ADDR_TSEL: begin
                next_prdata[1:0] = timerSelect;
            end
            ADDR_DIR: begin
                next_prdata[0] = pinDirectionBit;
            end
            ADDR_PINSTAT: begin
                next_prdata[1:0] = {pwmOutOe, pwmOutPin};
            end
            ADDR_FLAGS: begin
                next_prdata[2:0] = {timerMatchFlag[2], timerMatchFlag[1], timerMatchFlag[0]};
            end
            default: begin
                // timer blocks decode here, anything else is an error
                next_pslverr = 1'b1;
                // a hit on any timer register clears the error
                for (int i = 0; i < NUM_TIMERS; i++) begin
                    if (paddr == ADDR_TBASE + 8'(i) * TSTRIDE + OFS_TCTRL) begin
                        next_prdata[6:0] = timerControlReg[i];
                        next_pslverr = 1'b0;
                    end
                    if (paddr == ADDR_TBASE + 8'(i) * TSTRIDE + OFS_PERIOD) begin
                        next_prdata[7:0] = periodReg[i];
                        next_pslverr = 1'b0;
                    end
                    if (paddr == ADDR_TBASE + 8'(i) * TSTRIDE + OFS_COUNT) begin
                        next_prdata[7:0] = timerCount[i];
                        next_pslverr = 1'b0;
                    end
                end
            end
        endcase
    end

    // ****************************************************************
    // module registers
    // ****************************************************************
    // control, duty buffer, timer select, direction
    always_ff @(posedge clock) begin
        if (rst) begin
            // defaults; the direction bit leaves the pin as input
            moduleControlReg <= RST_CTRL;
            dutyHighBuffer <= RST_DUTYH;
            timerSelect <= RST_TSEL;
            pinDirectionBit <= RST_DIR;
        end else if (wrEn) begin
            // duty fields accepted at any time, used at next start
            case (paddr)
                ADDR_CTRL: moduleControlReg <= pwdata[7:0];
                ADDR_DUTYH: dutyHighBuffer <= pwdata[7:0];
                ADDR_TSEL: timerSelect <= pwdata[1:0];
                ADDR_DIR: pinDirectionBit <= pwdata[0];
                default: begin
                    // other offsets are kept by their own processes
                end
            endcase
        end
    end

    // ****************************************************************
    // timers: prescaler, count, period match, flag
    // ****************************************************************
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        localparam logic [7:0] BASE = ADDR_TBASE + 8'(t) * TSTRIDE;
        spwm_ps_t ps;
        logic [5:0] subEnd;
        logic tick;
        logic flagClr;
        logic stepNow; // last clock of a time base step

        assign ps = spwm_ps_t'(timerControlReg[t][TCTRL_PS_LSB +: 2]);

        // prescale end value; postscale bits not used here
        always_comb begin
            case (ps)
                PS_DIV1: subEnd = SUB_END_PS1;
                PS_DIV4: subEnd = SUB_END_PS4;
                default: subEnd = SUB_END_PS16;
            endcase
        end

        // sleep stops the timer, count is kept
        assign tick = timerControlReg[t][TCTRL_RUN_BIT] && !sleep && (subCount[t] == subEnd);
        assign periodStart[t] = tick && (timerCount[t] == periodReg[t]);
        assign flagClr = wrEn && (paddr == ADDR_FLAGS) && pwdata[t];

        // low two bits follow the prescale choice
        always_comb begin
            case (ps)
                PS_DIV1: timeBase[t] = {timerCount[t], subCount[t][1:0]};
                PS_DIV4: timeBase[t] = {timerCount[t], subCount[t][3:2]};
                default: timeBase[t] = {timerCount[t], subCount[t][5:4]};
            endcase
        end

        // the bits below the time base are all ones on its last clock
        always_comb begin
            case (ps)
                PS_DIV1: stepNow = 1'b1;
                PS_DIV4: stepNow = (subCount[t][1:0] == 2'h3);
                default: stepNow = (subCount[t][3:0] == 4'hf);
            endcase
        end

        // a stopped or sleeping timer never steps
        assign timeStep[t] = stepNow && timerControlReg[t][TCTRL_RUN_BIT] && !sleep;

        // timer control and period registers
        always_ff @(posedge clock) begin
            if (rst) begin
                timerControlReg[t] <= RST_TCTRL;
                periodReg[t] <= RST_PERIOD;
            end else if (wrEn && paddr == BASE + OFS_TCTRL) begin
                // postscale bits are kept for software only
                timerControlReg[t] <= pwdata[6:0];
            end else if (wrEn && paddr == BASE + OFS_PERIOD) begin
                periodReg[t] <= pwdata[7:0];
            end
        end

        // prescaler counts system clocks, four per tick at 1:1
        always_ff @(posedge clock) begin
            if (rst) begin
                subCount[t] <= 6'h00;
            end else if (wrEn && (paddr == BASE + OFS_TCTRL || paddr == BASE + OFS_COUNT)) begin
                // a new setting or count restarts the step
                subCount[t] <= 6'h00;
            end else if (timerControlReg[t][TCTRL_RUN_BIT] && !sleep) begin
                // counts only while running and awake
                subCount[t] <= (subCount[t] >= subEnd) ? 6'h00 : subCount[t] + 6'h01;
            end
        end

        // count wraps to zero one tick after reaching period
        always_ff @(posedge clock) begin
            if (rst) begin
                timerCount[t] <= RST_COUNT;
            end else if (wrEn && paddr == BASE + OFS_COUNT) begin
                // software load of the count
                timerCount[t] <= pwdata[7:0];
            end else if (periodStart[t]) begin
                // match with the period: wrap and start a new period
                timerCount[t] <= 8'h00;
            end else if (tick) begin
                // one step per prescaled tick
                timerCount[t] <= timerCount[t] + 8'h01;
            end
        end

        // match flag: a match in the clear cycle wins
        always_ff @(posedge clock) begin
            if (rst) begin
                timerMatchFlag[t] <= 1'b0;
            end else if (periodStart[t]) begin
                timerMatchFlag[t] <= 1'b1;
            end else if (flagClr) begin
                // software writes one to clear
                timerMatchFlag[t] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // timer selection
    // ****************************************************************
    // select code 3 falls back to the first timer
    always_comb begin
        case (timerSelect)
            2'h1: begin
                selStart = periodStart[1];
                selBase = timeBase[1];
                selStep = timeStep[1];
            end
            2'h2: begin
                selStart = periodStart[2];
                selBase = timeBase[2];
                selStep = timeStep[2];
            end
            default: begin
                // codes zero and three both take the first timer
                selStart = periodStart[0];
                selBase = timeBase[0];
                selStep = timeStep[0];
            end
        endcase
    end

    // ****************************************************************
    // duty double buffer
    // ****************************************************************
    // active duty loads at period start; bus writes only outside pwm
    always_ff @(posedge clock) begin
        if (rst) begin
            dutyActive <= RST_DUTYACT;
        end else if (running && selStart) begin
            // period start takes the buffered duty
            dutyActive <= {dutyHighBuffer, moduleControlReg[CTRL_DLOW_LSB +: 2]};
        end else if (wrEn && paddr == ADDR_DUTYACT && !pwmMode) begin
            // outside pwm software may load the eight msbs
            dutyActive <= {pwdata[7:0], dutyActive[1:0]};
        end
    end

    // ****************************************************************
    // waveform
    // ****************************************************************
    // set at start unless duty zero, cleared when time base meets
    // the active duty; a duty past the period never meets, so the
    // level holds; resolution is whatever the period allows
    // the fall is timed to the last clock of the step before the duty
    always_ff @(posedge clock) begin
        if (rst) begin
            pwmOutPin <= 1'b0;
        end else if (!pwmMode) begin
            // leaving pwm mode parks the pin low
            pwmOutPin <= 1'b0;
        end else if (sleep) begin
            // asleep the driven level is held
            pwmOutPin <= pwmOutPin;
        end else if (selStart) begin
            // new period: high unless the new duty is zero
            pwmOutPin <= ({dutyHighBuffer, moduleControlReg[CTRL_DLOW_LSB +: 2]} != 10'h000);
        end else if (selStep && selBase + 10'h001 == dutyActive) begin
            // low from the edge where the time base reaches the duty
            pwmOutPin <= 1'b0;
        end
    end

    // driver on only in pwm mode with direction cleared
    always_ff @(posedge clock) begin
        if (rst) begin
            pwmOutOe <= 1'b0;
        end else begin
            // high only while pwm mode owns the pin and direction is clear
            pwmOutOe <= pwmMode && !pinDirectionBit;
        end
    end
endmodule

// ---- tb/spwm_checker.sv ----
module spwm_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic sleep,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwmOutPin,
    input wire logic pwmOutOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // bus and pin properties
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // access phase opened by the master
    sequence accessOpenS;
        psel && $rose(penable);
    endsequence
    // one wait state, then the answer
    sequence oneWaitS;
        !pready ##1 pready;
    endsequence
    readyPulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    readyWait_a: assert property (accessOpenS |-> oneWaitS) else $error("pready not after one wait");
    errZero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    resetOut_a: assert property (disable iff (1'b0) rst |=> !pwmOutOe && !pwmOutPin) else $error("pin not freed");
    // the write lands at the access edge, the enable one edge later
    oeByWrite_a: assert property ($changed(pwmOutOe) |-> $past(psel && penable && pready && pwrite, 2))
        else $error("enable moved without write");
    sleepHold_a: assert property ((sleep && !psel)[*3] |-> $stable(pwmOutPin)) else $error("pin moved asleep");
    riseAwake_a: assert property ($rose(pwmOutPin) |-> !($past(sleep) && $past(sleep, 2)))
        else $error("pin rose asleep");
    pinOwned_a: assert property ($fell(pwmOutOe) && !pwmOutPin |=> !pwmOutPin) else $error("pin driven unowned");
endmodule

bind spwm_generator spwm_checker u_spwm_checker (.clock(clock), .rst(rst), .sleep(sleep), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwmOutPin(pwmOutPin), .pwmOutOe(pwmOutOe));

// ---- tb/spwm_load_model.sv ----
module spwm_load_model (
    input wire logic clock,
    input wire logic pwmOutPin,
    input wire logic pwmOutOe,
    output int highLen,
    output int periodLen,
    output int nRise
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // load with pull-down: an undriven pin reads low
    // ****************************************************************
    logic lvl;
    logic prev = 1'b0;
    int cnt = 0;
    assign lvl = pwmOutOe ? pwmOutPin : 1'b0;
    initial begin
        highLen = 0;
        periodLen = 0;
        nRise = 0;
    end
    // measure high time and rise-to-rise period in clocks
    always @(posedge clock) begin
        prev <= lvl;
        if (lvl && !prev) begin
            periodLen <= cnt;
            cnt <= 1;
            nRise <= nRise + 1;
        end else begin
            cnt <= cnt + 1;
        end
        if (!lvl && prev) begin
            highLen <= cnt;
        end
    end
endmodule

// ---- tb/tb_spwm_generator.sv ----
module tb_spwm_generator;
    timeunit 1ns;
    timeprecision 1ps;
    import spwm_pkg::*;
    localparam logic [7:0] T1 = ADDR_TBASE + TSTRIDE;  // second timer block
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pwmOutPin;
    logic pwmOutOe;
    logic [31:0] q;
    logic [31:0] q2;
    logic e;
    int highLen;
    int periodLen;
    int nRise;
    int n_mismatch = 0;
    int checks_done = 0;
    spwm_generator u_spwm_generator (.clock(clock), .rst(rst), .sleep(sleep), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwmOutPin(pwmOutPin), .pwmOutOe(pwmOutOe));
    spwm_load_model u_spwm_load_model (.clock(clock), .pwmOutPin(pwmOutPin), .pwmOutOe(pwmOutOe),
        .highLen(highLen), .periodLen(periodLen), .nRise(nRise));
    // ****************************************************************
    // tasks
    // ****************************************************************
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer: setup, access held until pready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        // one edge after any release, so no signal is set twice at once
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp32(q, exp);
    endtask
    // skip a rise that may belong to the old setting, then compare
    // the last full period and its high time
    task automatic measure(input int hi, input int per);
        int r;
        r = nRise;
        while (nRise < r + 3) @(posedge clock);
        cmp32(highLen, hi);
        cmp32(periodLen, per);
    endtask
    // pin must hold one level with no new pulse
    task automatic steady(input logic lv);
        int r;
        repeat (40) @(posedge clock);
        r = nRise;
        repeat (48) @(posedge clock);
        cmp32(nRise, r);
        cmp32({31'h0, pwmOutPin}, {31'h0, lv});
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        int f;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdChk(ADDR_CTRL, 32'h0);
        rdChk(ADDR_DIR, 32'h1);
        rdChk(T1 + OFS_PERIOD, 32'hff);
        rdChk(ADDR_DUTYACT, 32'h0);
        rdChk(8'h1c, 32'h0);
        cmp32({31'h0, e}, 32'h1);
        xfer(1'b1, ADDR_DIR, 32'h1);
        xfer(1'b1, ADDR_TSEL, 32'h1);
        xfer(1'b1, T1 + OFS_PERIOD, 32'h3);
        xfer(1'b1, ADDR_CTRL, 32'h2c);
        xfer(1'b1, ADDR_DUTYH, 32'h1);
        xfer(1'b1, ADDR_FLAGS, 32'h7);
        xfer(1'b1, T1 + OFS_TCTRL, 32'h4);
        repeat (40) @(posedge clock);
        rdChk(ADDR_FLAGS, 32'h2);
        xfer(1'b1, ADDR_DIR, 32'h0);
        repeat (2) @(posedge clock);
        cmp32({31'h0, pwmOutOe}, 32'h1);
        rdChk(ADDR_DUTYACT, 32'h6);
        xfer(1'b1, ADDR_DUTYACT, 32'h0);
        rdChk(ADDR_DUTYACT, 32'h6);
        // prescale codes zero to two, not the alias three; postscale bits set and ignored
        for (int ps = 0; ps < 3; ps++) begin
            f = (ps == 0) ? 1 : ((ps == 1) ? 4 : 16);
            xfer(1'b1, T1 + OFS_TCTRL, 32'h7c | ps);
            measure(6 * f, 16 * f);
        end
        xfer(1'b1, T1 + OFS_TCTRL, 32'h4);
        xfer(1'b1, ADDR_DUTYH, 32'h2);
        measure(10, 16);
        sleep <= 1'b1;
        xfer(1'b0, T1 + OFS_COUNT, 32'h0);
        q2 = q;
        repeat (30) @(posedge clock);
        rdChk(T1 + OFS_COUNT, q2);
        sleep <= 1'b0;
        xfer(1'b1, ADDR_DUTYH, 32'h0);
        xfer(1'b1, ADDR_CTRL, 32'h0c);
        steady(1'b0);
        xfer(1'b1, ADDR_DUTYH, 32'hff);
        xfer(1'b1, ADDR_CTRL, 32'h3c);
        steady(1'b1);
        xfer(1'b1, ADDR_CTRL, 32'h0);
        repeat (4) @(posedge clock);
        cmp32({31'h0, pwmOutOe}, 32'h0);
        report_and_stop();
    end
    // watchdog against a hung handshake or pin
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end
endmodule
